// File: hw/pin_cfg_pkg.sv
// package for the multifunction pin configuration block:
// register offsets, reset values, field positions, role and direction codes.
// assumes a single 125 MHz system clock.
package pin_cfg_pkg;

  localparam int NUM_PINS = 4;

  // register offsets on the control port
  localparam logic [7:0] ADDR_ROLE01  = 8'h10;
  localparam logic [7:0] ADDR_ROLE23  = 8'h11;
  localparam logic [7:0] ADDR_DIR01   = 8'h12;
  localparam logic [7:0] ADDR_DIR23   = 8'h13;
  localparam logic [7:0] ADDR_PIN_STS = 8'h14;

  // reset values
  localparam logic [7:0] RST_ROLE01 = 8'h01;
  localparam logic [7:0] RST_ROLE23 = 8'h20;
  localparam logic [7:0] RST_DIR    = 8'h00;
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam logic [7:0] READ_ZERO  = 8'h00;

  // field positions: each role and direction byte holds a low pin and a high pin
  localparam int ROLE_LO_LSB = 0;
  localparam int INV_LO_BIT  = 3;
  localparam int ROLE_HI_LSB = 4;
  localparam int INV_HI_BIT  = 7;
  localparam int DIR_LO_LSB  = 0;
  localparam int DIR_HI_LSB  = 4;
  localparam int STS_OUT_LSB = 4;

  // role codes (meaning of 001 and 010 depends on the pin)
  localparam logic [2:0] ROLE_GPIO  = 3'h0;
  localparam logic [2:0] ROLE_ALT1  = 3'h1;
  localparam logic [2:0] ROLE_ALT2  = 3'h2;
  localparam logic [2:0] ROLE_SCK   = 3'h3;
  localparam logic [2:0] ROLE_MUTE  = 3'h4;
  localparam logic [2:0] ROLE_SECOND_SERIAL_DATA_OUT = 3'h5;
  localparam logic [2:0] ROLE_DIN   = 3'h6;

  // direction codes in general purpose mode
  localparam logic [2:0] DIR_IN     = 3'h0;
  localparam logic [2:0] DIR_STICKY = 3'h1;
  localparam logic [2:0] DIR_TOGGLE = 3'h2;
  localparam logic [2:0] DIR_RAW    = 3'h3;
  localparam logic [2:0] DIR_OUT    = 3'h4;
  localparam logic [2:0] DIR_OD     = 3'h5;

  // deglitch filter time
  localparam int CLK_PERIOD_NS = 8;
  localparam int DEGLITCH_NS   = 40;
  localparam int DEGLITCH_CYC  = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // per-pin configuration taken from the registers
  typedef struct packed {
    logic       invert;
    logic [2:0] role;
    logic [2:0] dir;
  } pin_cfg_s;

  // conditioned view of one pin input
  typedef struct packed {
    logic level;   // deglitched level
    logic raw;     // synchronised, unfiltered level
    logic change;  // one-cycle pulse when level changes
  } pin_sense_s;

endpackage

// File: hw/pin_sense.sv
// input conditioner for one multifunction pin: three-flop synchroniser
// and a deglitch filter. assumes the pin is asynchronous to sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
module pin_sense
  import pin_cfg_pkg::*;
#(
  parameter int FILT_CYC = DEGLITCH_CYC
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       pin_i,
  output var  pin_sense_s sense_o
);

  localparam int CW = $clog2(FILT_CYC + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(FILT_CYC - 1);

  logic [2:0]    sync_r;
  logic [2:0]    sync_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          level_r;
  logic          level_nxt;
  logic          change_r;
  logic          change_nxt;

  // a change counts once the second and third stage agree and stay away from
  // the filtered level for the whole filter time; the first stage feeds only the second
  always_comb begin
    sync_nxt   = {sync_r[1:0], pin_i};
    cnt_nxt    = '0;
    level_nxt  = level_r;
    change_nxt = 1'b0;
    if ((sync_r[1] == sync_r[2]) && (sync_r[2] != level_r)) begin
      if (cnt_r == CNT_LAST) begin
        level_nxt  = sync_r[2];
        change_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + CW'(1);
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_r   <= 3'h0;
      cnt_r    <= '0;
      level_r  <= 1'b0;
      change_r <= 1'b0;
    end else begin
      sync_r   <= sync_nxt;
      cnt_r    <= cnt_nxt;
      level_r  <= level_nxt;
      change_r <= change_nxt;
    end
  end

  assign sense_o = '{level: level_r, raw: sync_r[2], change: change_r};

endmodule // pin_sense
`default_nettype wire

// File: hw/pin_cfg.sv
// multifunction pin configuration: role, polarity and direction registers
// for four pins, pin muxing and the pin status register.
// assumes a control port front end (serial, outside) that presents one-cycle
// read and write strobes with an 8-bit address; internal sources are on sys_clk_i.
//
// Notes on behaviour
// - pin 1 role 001 routes the pin in as digital microphone data 1.
// - pin 2 role 001 drives digital microphone clock 0 out.
// - role 011 on pins 1 to 3 drives the internal system clock out; the code also drives it out on pin 0.
// - role 100 on pins 1 to 3 makes the pin a digital mute input; the code also takes pin 0 as a mute input.
// - role byte for pins 0 and 1 resets to 0x01.
// - role byte for pins 2 and 3 resets to 0x20.
// - direction field acts only in general purpose role; direction bytes reset to 0x00.
// - direction codes: input, sticky, toggle, raw, output, open drain; 110/111 reserved.
// - sticky flag holds until the status register is read; that read clears it unless the input is still asserted.
`timescale 1ns/1ps
`default_nettype none
module pin_cfg
  import pin_cfg_pkg::*;
#(
  parameter int FILT_CYC = DEGLITCH_CYC
) (
  input  wire logic                sys_clk_i,
  input  wire logic                rst_n_i,
  input  wire logic [7:0]          reg_addr_i,
  input  wire logic [7:0]          reg_wdata_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  output var  logic [7:0]          reg_rdata_o,
  input  wire logic [NUM_PINS-1:0] pin_in_i,
  output var  logic [NUM_PINS-1:0] pin_out_o,
  output var  logic [NUM_PINS-1:0] pin_oe_n_o,
  input  wire logic                dmic_clk0_i,
  input  wire logic                sck_i,
  input  wire logic                irq_i,
  input  wire logic                spi_miso_i,
  input  wire logic                second_serial_data_out_i,
  output var  logic                dmic_data0_o,
  output var  logic                dmic_data1_o,
  output var  logic                mute_o,
  output var  logic                serial_data_in_o
);

  logic [7:0]          role01_r, role01_nxt;
  logic [7:0]          role23_r, role23_nxt;
  logic [7:0]          dir01_r, dir01_nxt;
  logic [7:0]          dir23_r, dir23_nxt;
  logic [3:0]          out_bits_r, out_bits_nxt;
  logic [3:0]          flag_r, flag_nxt;
  logic [7:0]          rdata_nxt;
  logic [NUM_PINS-1:0] pin_out_nxt, pin_oe_n_nxt;
  logic [NUM_PINS-1:0] in_val, flag_set, is_mute, is_din;
  logic                dmic0_nxt, dmic1_nxt, mute_nxt, din_nxt;
  logic                sts_read;
  pin_cfg_s            cfg [NUM_PINS];
  pin_sense_s          sense [NUM_PINS];

  // unpack the register bytes into one configuration per pin
  assign cfg[0] = '{invert: role01_r[INV_LO_BIT], role: role01_r[ROLE_LO_LSB +: 3], dir: dir01_r[DIR_LO_LSB +: 3]};
  assign cfg[1] = '{invert: role01_r[INV_HI_BIT], role: role01_r[ROLE_HI_LSB +: 3], dir: dir01_r[DIR_HI_LSB +: 3]};
  assign cfg[2] = '{invert: role23_r[INV_LO_BIT], role: role23_r[ROLE_LO_LSB +: 3], dir: dir23_r[DIR_LO_LSB +: 3]};
  assign cfg[3] = '{invert: role23_r[INV_HI_BIT], role: role23_r[ROLE_HI_LSB +: 3], dir: dir23_r[DIR_HI_LSB +: 3]};

  assign sts_read = reg_rd_i && (reg_addr_i == ADDR_PIN_STS);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      logic gpio_mode;
      logic out_val;

      pin_sense #(.FILT_CYC(FILT_CYC)) u_sense (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .pin_i     (pin_in_i[gi]),
        .sense_o   (sense[gi])
      );

      assign gpio_mode = (cfg[gi].role == ROLE_GPIO);
      // raw mode skips the deglitch filter; polarity applies in every role
      assign in_val[gi] = ((gpio_mode && (cfg[gi].dir == DIR_RAW)) ? sense[gi].raw
                                                                    : sense[gi].level) ^ cfg[gi].invert;
      assign is_mute[gi] = (cfg[gi].role == ROLE_MUTE) && in_val[gi];
      assign is_din[gi]  = (cfg[gi].role == ROLE_DIN) && in_val[gi];
      // sticky sets on an asserted level, toggle on a filtered change
      assign flag_set[gi] = gpio_mode && (((cfg[gi].dir == DIR_STICKY) && in_val[gi]) ||
                                          ((cfg[gi].dir == DIR_TOGGLE) && sense[gi].change));

      // pin driver: output enable is low while the pin is driven
      always_comb begin
        out_val          = 1'b0;
        pin_oe_n_nxt[gi] = 1'b1;
        unique case (cfg[gi].role)
          ROLE_GPIO: begin
            // direction only matters in the general purpose role
            if (cfg[gi].dir == DIR_OUT) begin
              out_val          = out_bits_r[gi];
              pin_oe_n_nxt[gi] = 1'b0;
            end else if (cfg[gi].dir == DIR_OD) begin
              // open drain pulls low only, a high level is left to the pull-up;
              // out_val carries the polarity bit so the xor below keeps the driven level low
              out_val          = cfg[gi].invert;
              pin_oe_n_nxt[gi] = out_bits_r[gi] ^ cfg[gi].invert;
            end
          end
          ROLE_ALT1: begin
            if (gi == 2) begin
              out_val          = dmic_clk0_i;
              pin_oe_n_nxt[gi] = 1'b0;
            end
          end
          ROLE_ALT2: begin
            out_val          = (gi == 0) ? spi_miso_i : irq_i;
            pin_oe_n_nxt[gi] = 1'b0;
          end
          ROLE_SCK: begin
            out_val          = sck_i;
            pin_oe_n_nxt[gi] = 1'b0;
          end
          ROLE_SECOND_SERIAL_DATA_OUT: begin
            out_val          = second_serial_data_out_i;
            pin_oe_n_nxt[gi] = 1'b0;
          end
          default: begin
            out_val          = 1'b0;
            pin_oe_n_nxt[gi] = 1'b1;
          end
        endcase
        pin_out_nxt[gi] = (pin_oe_n_nxt[gi] ? 1'b0 : out_val) ^ (~pin_oe_n_nxt[gi] & cfg[gi].invert);
      end
    end
  endgenerate

  // routed functions; dmic inputs are only seen in their own role
  always_comb begin
    dmic0_nxt = (cfg[0].role == ROLE_ALT1) && in_val[0];
    dmic1_nxt = (cfg[1].role == ROLE_ALT1) && in_val[1];
    mute_nxt  = |is_mute;
    din_nxt   = |is_din;
  end

  // register writes, status flags and read data
  always_comb begin
    role01_nxt   = role01_r;
    role23_nxt   = role23_r;
    dir01_nxt    = dir01_r;
    dir23_nxt    = dir23_r;
    out_bits_nxt = out_bits_r;
    rdata_nxt    = READ_ZERO;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        ADDR_ROLE01:  role01_nxt   = reg_wdata_i;
        ADDR_ROLE23:  role23_nxt   = reg_wdata_i;
        ADDR_DIR01:   dir01_nxt    = reg_wdata_i;
        ADDR_DIR23:   dir23_nxt    = reg_wdata_i;
        ADDR_PIN_STS: out_bits_nxt = reg_wdata_i[STS_OUT_LSB +: 4];
        default:      role01_nxt   = role01_r;   // unmapped writes are ignored
      endcase
    end
    for (int i = 0; i < NUM_PINS; i++) begin
      if ((cfg[i].role == ROLE_GPIO) && ((cfg[i].dir == DIR_STICKY) || (cfg[i].dir == DIR_TOGGLE))) begin
        flag_nxt[i] = flag_set[i] | (flag_r[i] & ~sts_read);
      end else begin
        flag_nxt[i] = in_val[i];
      end
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_ROLE01:  rdata_nxt = role01_r;
        ADDR_ROLE23:  rdata_nxt = role23_r;
        ADDR_DIR01:   rdata_nxt = dir01_r;
        ADDR_DIR23:   rdata_nxt = dir23_r;
        ADDR_PIN_STS: rdata_nxt = {out_bits_r, flag_r};
        default:      rdata_nxt = READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      role01_r         <= RST_ROLE01;
      role23_r         <= RST_ROLE23;
      dir01_r          <= RST_DIR;
      dir23_r          <= RST_DIR;
      out_bits_r       <= RST_NIBBLE;
      flag_r           <= RST_NIBBLE;
      reg_rdata_o      <= READ_ZERO;
      pin_out_o        <= RST_NIBBLE;
      pin_oe_n_o       <= 4'hF;
      dmic_data0_o     <= 1'b0;
      dmic_data1_o     <= 1'b0;
      mute_o           <= 1'b0;
      serial_data_in_o <= 1'b0;
    end else begin
      role01_r         <= role01_nxt;
      role23_r         <= role23_nxt;
      dir01_r          <= dir01_nxt;
      dir23_r          <= dir23_nxt;
      out_bits_r       <= out_bits_nxt;
      flag_r           <= flag_nxt;
      reg_rdata_o      <= rdata_nxt;
      pin_out_o        <= pin_out_nxt;
      pin_oe_n_o       <= pin_oe_n_nxt;
      dmic_data0_o     <= dmic0_nxt;
      dmic_data1_o     <= dmic1_nxt;
      mute_o           <= mute_nxt;
      serial_data_in_o <= din_nxt;
    end
  end

  // checks on the pin muxing and the registers
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_dmic1_route: assert property ((cfg[1].role == ROLE_ALT1) |=> dmic_data1_o == $past(in_val[1]))
    else $error("dmic data 1 not routed from pin 1");
  a_dmic_clk_out: assert property ((cfg[2].role == ROLE_ALT1) |=>
                                   !pin_oe_n_o[2] && (pin_out_o[2] == ($past(dmic_clk0_i) ^ $past(cfg[2].invert))))
    else $error("dmic clock not driven on pin 2");
  a_sck_out: assert property ((cfg[1].role == ROLE_SCK) |=>
                              !pin_oe_n_o[1] && (pin_out_o[1] == ($past(sck_i) ^ $past(cfg[1].invert))))
    else $error("system clock not driven on pin 1");
  a_mute_input: assert property ((cfg[1].role == ROLE_MUTE) && in_val[1] |=> mute_o && pin_oe_n_o[1])
    else $error("mute input on pin 1 not honoured");
  a_role01_reset: assert property (@(posedge sys_clk_i) $rose(rst_n_i) |-> role01_r == RST_ROLE01)
    else $error("pin 0/1 role byte wrong after reset");
  a_role23_reset: assert property (@(posedge sys_clk_i) $rose(rst_n_i) |->
                                   role23_r == RST_ROLE23 && dir01_r == RST_DIR)
    else $error("pin 2/3 role byte wrong after reset");
  a_dir_gated: assert property ((cfg[0].role == ROLE_MUTE) |=> pin_oe_n_o[0])
    else $error("direction acted outside general purpose role");
  a_gpio_invert: assert property ((cfg[0].role == ROLE_GPIO) && (cfg[0].dir == DIR_OUT) |=>
                                  pin_out_o[0] == ($past(out_bits_r[0]) ^ $past(cfg[0].invert)))
    else $error("output polarity wrong on pin 0");
  a_open_drain: assert property ((cfg[0].role == ROLE_GPIO) && (cfg[0].dir == DIR_OD) |=>
                                 !pin_out_o[0] && (pin_oe_n_o[0] == ($past(out_bits_r[0]) ^ $past(cfg[0].invert))))
    else $error("open drain pin 0 drives wrongly");
  a_sticky_hold: assert property ((cfg[0].role == ROLE_GPIO) && (cfg[0].dir == DIR_STICKY) && flag_r[0] && !sts_read
                                  ##0 (cfg[0].role == ROLE_GPIO) |=> flag_r[0] || $past(cfg[0].dir) != DIR_STICKY)
    else $error("sticky flag lost without a status read");
  a_sticky_clear: assert property (sts_read && (cfg[0].role == ROLE_GPIO) && (cfg[0].dir == DIR_STICKY) && !flag_set[0]
                                   |=> !flag_r[0])
    else $error("status read did not clear sticky flag");

  c_mute: cover property (mute_o);
  c_sticky_read: cover property (flag_r[0] ##1 sts_read ##1 !flag_r[0]);
  c_dmic_clk: cover property ((cfg[2].role == ROLE_ALT1) ##2 pin_out_o[2]);
  c_open_drain_low: cover property ((cfg[0].dir == DIR_OD) && !pin_oe_n_o[0]);

endmodule // pin_cfg
`default_nettype wire

// File: sim/ctrl_host_model.sv
// host model for the control port: one-byte register writes and reads
// assumes strobes are sampled on the rising edge of sys_clk_i
`timescale 1ns/1ps
`default_nettype none
module ctrl_host_model (
  input  wire logic       sys_clk_i,
  output var  logic [7:0] reg_addr_o,
  output var  logic [7:0] reg_wdata_o,
  output var  logic       reg_wr_o,
  output var  logic       reg_rd_o,
  input  wire logic [7:0] reg_rdata_i
);
  // idle bus at time zero
  initial begin
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
  end

  // write: strobe held until the taking edge, then released lines are scrambled
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk_i);
    reg_addr_o  <= addr;
    reg_wdata_o <= data;
    reg_wr_o    <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_o    <= 1'b0;
    reg_addr_o  <= ~addr;  // stale values must not be relied on
    reg_wdata_o <= ~data;
  endtask

  // read: data is registered at the taking edge and stands one cycle
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge sys_clk_i);
    reg_addr_o <= addr;
    reg_rd_o   <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_o   <= 1'b0;
    reg_addr_o <= ~addr;
    #1 data = reg_rdata_i;
  endtask
endmodule // ctrl_host_model
`default_nettype wire

// File: sim/pin_cfg_tb.sv
// self-checking bench for pin_cfg: register table rows, then pin role cases
// assumes the deglitch filter is shortened to one cycle to keep waits small
`timescale 1ns/1ps
`default_nettype none
module pin_cfg_tb;
  import pin_cfg_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
  logic reg_wr, reg_rd;
  logic [3:0] pin_in = 4'h0;
  logic [3:0] pin_out, pin_oe_n;
  logic dmic_clk0 = 1'b0, sck = 1'b0, irq = 1'b1;
  logic dmic_data0, dmic_data1, mute, sdin;
  int num_errors = 0, comparisons = 0, cycles = 0;
  typedef struct {logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} row_s;
  row_s rows [9] = '{'{8'h10, 8'h00, 8'h00}, '{8'h11, 8'h00, 8'h00}, '{8'h14, 8'hAB, 8'hA0},
                     '{8'h12, 8'h88, 8'h88}, '{8'h13, 8'hF7, 8'hF7}, '{8'h20, 8'hFF, 8'h00},
                     '{8'h12, 8'h00, 8'h00}, '{8'h13, 8'h00, 8'h00}, '{8'h14, 8'h00, 8'h00}};

  always #4 sys_clk_i = ~sys_clk_i;

  ctrl_host_model u_ctrl_host_model (.sys_clk_i(sys_clk_i), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
    .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata));

  pin_cfg #(.FILT_CYC(1)) u_pin_cfg (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_n_o(pin_oe_n), .dmic_clk0_i(dmic_clk0), .sck_i(sck),
    .irq_i(irq), .spi_miso_i(1'b0), .second_serial_data_out_i(1'b0), .dmic_data0_o(dmic_data0),
    .dmic_data1_o(dmic_data1), .mute_o(mute), .serial_data_in_o(sdin));

  // compare one value, count it, report a mismatch at once
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic complete_run();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      complete_run();
    end
  end

  initial begin
    wait_clk(3);
    chk({4'h0, pin_oe_n}, 8'h0F);  // all pins released during reset
    rst_n_i <= 1'b1;
    wait_clk(3);
    chk({7'h00, pin_out[3]}, {7'h00, irq});
    chk({4'h0, pin_oe_n}, 8'h07);
    u_ctrl_host_model.rd(8'h10, rd_val);
    chk(rd_val, 8'h01);
    u_ctrl_host_model.rd(8'h11, rd_val);
    chk(rd_val, 8'h20);
    u_ctrl_host_model.rd(8'h12, rd_val);
    chk(rd_val, 8'h00);
    // register rows: reserved bits kept, status low nibble read-only, unmapped ignored
    foreach (rows[i]) begin
      u_ctrl_host_model.wr(rows[i].addr, rows[i].wdata);
      u_ctrl_host_model.rd(rows[i].addr, rd_val);
      chk(rd_val, rows[i].exp);
    end
    // internal system clock out on pin 1, plain and inverted
    u_ctrl_host_model.wr(8'h10, 8'h30);
    sck <= 1'b1;
    wait_clk(3);
    chk({6'h00, pin_oe_n[1], pin_out[1]}, 8'h01);
    sck <= 1'b0;
    wait_clk(3);
    chk({6'h00, pin_oe_n[1], pin_out[1]}, 8'h00);
    u_ctrl_host_model.wr(8'h10, 8'hB0);
    wait_clk(3);
    chk({7'h00, pin_out[1]}, 8'h01);
    // microphone clock out on pin 2, plain and inverted
    u_ctrl_host_model.wr(8'h11, 8'h01);
    dmic_clk0 <= 1'b1;
    wait_clk(3);
    chk({6'h00, pin_oe_n[2], pin_out[2]}, 8'h01);
    u_ctrl_host_model.wr(8'h11, 8'h09);
    wait_clk(3);
    chk({6'h00, pin_oe_n[2], pin_out[2]}, 8'h00);
    // back to plain general purpose so pin 2 reads low in the status byte
    u_ctrl_host_model.wr(8'h11, 8'h00);
    // microphone data in on pin 1 through sync and filter
    u_ctrl_host_model.wr(8'h10, 8'h10);
    pin_in[1] <= 1'b1;
    wait_clk(12);
    chk({7'h00, dmic_data1}, 8'h01);
    u_ctrl_host_model.wr(8'h10, 8'h90);
    wait_clk(3);
    chk({7'h00, dmic_data1}, 8'h00);
    // mute input on pin 1, pin stays released
    u_ctrl_host_model.wr(8'h10, 8'h40);
    wait_clk(3);
    chk({6'h00, pin_oe_n[1], mute}, 8'h03);
    pin_in[1] <= 1'b0;
    wait_clk(12);
    chk({7'h00, mute}, 8'h00);
    // general purpose output, open drain, and direction ignored outside that role
    u_ctrl_host_model.wr(8'h10, 8'h00);
    u_ctrl_host_model.wr(8'h12, 8'h04);
    u_ctrl_host_model.wr(8'h14, 8'h10);
    wait_clk(3);
    chk({6'h00, pin_oe_n[0], pin_out[0]}, 8'h01);
    u_ctrl_host_model.wr(8'h12, 8'h05);
    wait_clk(3);
    chk({7'h00, pin_oe_n[0]}, 8'h01);
    u_ctrl_host_model.wr(8'h14, 8'h00);
    wait_clk(3);
    chk({6'h00, pin_oe_n[0], pin_out[0]}, 8'h00);
    u_ctrl_host_model.wr(8'h10, 8'h04);
    wait_clk(3);
    chk({7'h00, pin_oe_n[0]}, 8'h01);
    // sticky flag survives the pin going low, cleared by the status read
    u_ctrl_host_model.wr(8'h10, 8'h00);
    u_ctrl_host_model.wr(8'h12, 8'h01);
    pin_in[0] <= 1'b1;
    wait_clk(12);
    pin_in[0] <= 1'b0;
    wait_clk(12);
    u_ctrl_host_model.rd(8'h14, rd_val);
    chk(rd_val, 8'h01);
    u_ctrl_host_model.rd(8'h14, rd_val);
    chk(rd_val, 8'h00);
    // toggle flag: set by a change, cleared by read though the pin stays high
    u_ctrl_host_model.wr(8'h12, 8'h02);
    u_ctrl_host_model.rd(8'h14, rd_val);
    pin_in[0] <= 1'b1;
    wait_clk(12);
    u_ctrl_host_model.rd(8'h14, rd_val);
    chk(rd_val, 8'h01);
    u_ctrl_host_model.rd(8'h14, rd_val);
    chk(rd_val, 8'h00);
    // serial data input on pin 2, inverted so a low pin reads high
    u_ctrl_host_model.wr(8'h11, 8'h0E);
    wait_clk(3);
    chk({7'h00, sdin}, 8'h01);
    // second reset in mid-run restores defaults
    rst_n_i <= 1'b0;
    wait_clk(2);
    chk({4'h0, pin_oe_n}, 8'h0F);  // released while in reset
    rst_n_i <= 1'b1;
    wait_clk(1);
    u_ctrl_host_model.rd(8'h12, rd_val);
    chk(rd_val, 8'h00);
    u_ctrl_host_model.rd(8'h10, rd_val);
    chk(rd_val, 8'h01);
    // pin 0 is back in its microphone data role and the pin is still high
    wait_clk(3);
    chk({7'h00, dmic_data0}, 8'h01);
    complete_run();
  end
endmodule // pin_cfg_tb
`default_nettype wire
